/* hw/adccmd_pkg.sv */
// Purpose: constants and types for the ADC command decoder
// Assumes: command bytes arrive MSB first over the serial port
// Notes:   delays are counted in conversion-clock ticks
`default_nettype none
package adccmd_pkg;
  // command byte fields
  localparam int SEL_SCAN_BIT = 7;
  localparam int SEL_CFG_BIT  = 6;
  localparam int CH_HI        = 5;
  localparam int CH_LO        = 3;
  localparam int SCAN_HI      = 2;
  localparam int SCAN_LO      = 1;
  localparam int TEMP_BIT     = 0;
  localparam int CK_HI        = 5;
  localparam int CK_LO        = 4;
  localparam int REF_HI       = 3;
  localparam int REF_LO       = 2;
  localparam int PAIR_HI      = 1;
  localparam int PAIR_LO      = 0;
  // reset values: clock mode 10, reference mode 10, no pairing byte
  localparam logic [5:0] CFG_RESET  = 6'h28;
  localparam logic [7:0] PAIR_RESET = 8'h00;
  localparam logic [7:0] SCAN_RESET = 8'h80;
  // delays in conversion clock cycles
  localparam logic [7:0] DLY_AIN_WAKE  = 8'hda;  // 218
  localparam logic [7:0] DLY_TEMP_WAKE = 8'hf4;  // 244
  localparam logic [7:0] DLY_TEMP_HELD = 8'hbc;  // 188
  localparam logic [2:0] LAST_CH       = 3'h7;
  localparam logic [2:0] PAIR_MSB      = 3'h7;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    SCAN_TO_N, SCAN_FROM_N, SCAN_REPEAT, SCAN_SINGLE
  } adccmd_scan_e;

  typedef enum logic [2:0] {
    SQ_IDLE, SQ_WAKE, SQ_TEMP, SQ_NEXT, SQ_WAIT
  } adccmd_seq_e;
endpackage
`default_nettype wire

/* hw/adccmd_decoder.sv */
// Purpose: decode ADC scan/setup command bytes and sequence scans
// Assumes: serial and convert-start pins are asynchronous to mclk_in
// Notes:   analog conversion is outside; conv_done_in ends each one
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - bits 7:6 = 01 write setup byte
// - bit 7 set writes scan command
// - scan bits 5:3 give channel N
// - mode 00 converts channels 0..N
// - mode 01 converts channels N..7
// - mode 10 repeats N, count from averaging
// - mode 11 converts N once only
// - bit 0 adds temperature, converted first
// - setup bits 5:4 clock mode, hi resets one
// - modes 00/10 internal timing; 10 pin is ANALOG_INPUT_SEVEN
// - mode 01 acquisition timed by start pin
// - mode 11 serial clock drives conversion timing
// - setup bits 3:2 select reference mode
// - setup bits 1:0 pick pairing register
// - force bit keeps reference powered
// - mode 00 and DAC up keeps reference
// - mode 00 and DAC pulled keeps reference
// - held reference: temperature waits 188 cycles
// - modes 00/10 ref off after scan, 218 wake
// - temperature powers reference, waits 244 cycles
// - modes 01/11 inputs skip internal reference
// - reference mode 10 is default
// - ref-two pin is ANALOG_INPUT_SIX in 00/10
// - modes 1x start on write, 0x pin
// - select 10/11: next byte to pairing register
// - skip start/ref pins; pairs ignore bit0
module adccmd_decoder
  import adccmd_pkg::*;
(
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // serial command port and start pin
  input  wire logic       sclk_in,
  input  wire logic       cs_n_in,
  input  wire logic       sdi_in,
  input  wire logic       convert_start_pin_n_in,
  // state of neighbouring blocks
  input  wire logic       force_reference_on_in,
  input  wire logic       dac_powered_up_in,
  input  wire logic       dac_pulled_to_ref_in,
  input  wire logic [4:0] repeat_results_in,
  input  wire logic       conv_done_in,
  // configuration
  output logic [1:0]      clock_mode_out,
  output logic [1:0]      reference_mode_out,
  output logic [7:0]      unipolar_pairs_out,
  output logic [7:0]      bipolar_pairs_out,
  output logic            analog_input_seven_sel_out,
  output logic            reference_pin_two_is_ref_out,
  output logic            reference_power_out,
  // conversion requests
  output logic            conv_req_out,
  output logic [2:0]      conv_channel_out,
  output logic            conv_temp_out,
  output logic            conv_differential_out,
  output logic            conv_bipolar_out,
  output logic            scan_busy_out,
  // bytes for other decoders
  output logic            other_cmd_valid_out,
  output logic [7:0]      other_cmd_byte_out
);
  import adccmd_pkg::*;

  function automatic logic pair_bit(input logic [2:0] c, input logic [7:0] r);
    pair_bit = r[PAIR_MSB - {1'b0, c[2:1]}];
  endfunction

  // pins doubling as start or ref-two inputs are never converted
  function automatic logic ch_blocked(input logic [2:0] c, input logic [5:0] cfg,
                                      input logic [7:0] diff);
    logic bad6;
    logic bad7;
    bad6 = cfg[REF_LO];
    bad7 = ~cfg[CK_HI];
    if (pair_bit(c, diff)) begin
      ch_blocked = c[0] | ((c[2:1] == 2'b11) & (bad6 | bad7));
    end else begin
      ch_blocked = ((c == 3'h7) & bad7) | ((c == 3'h6) & bad6);
    end
  endfunction

  // front end state
  logic [2:0] sclk_s_ff, nxt_sclk_s;
  logic [1:0] cs_s_ff, nxt_cs_s;
  logic [1:0] sdi_s_ff, nxt_sdi_s;
  logic [2:0] cnv_s_ff, nxt_cnv_s;
  logic [6:0] shift_ff, nxt_shift;
  logic [2:0] bits_ff, nxt_bits;
  logic       pair_pend_ff, nxt_pair_pend;
  logic       other_mode_ff, nxt_other_mode;
  logic [5:0] cfg_ff, nxt_cfg;
  logic [7:0] scan_ff, nxt_scan;
  logic       scan_wr_ff, nxt_scan_wr;
  logic [7:0] uni_ff, nxt_uni;
  logic [7:0] bip_ff, nxt_bip;
  logic       oth_v_ff, nxt_oth_v;
  logic [7:0] oth_b_ff, nxt_oth_b;
  logic       sclk_rise;
  logic       byte_done;
  logic [7:0] rx_byte;

  always_comb begin
    // first stage feeds only the second stage
    nxt_sclk_s = {sclk_s_ff[1:0], sclk_in};
    nxt_cs_s   = {cs_s_ff[0], cs_n_in};
    nxt_sdi_s  = {sdi_s_ff[0], sdi_in};
    nxt_cnv_s  = {cnv_s_ff[1:0], convert_start_pin_n_in};
    sclk_rise  = sclk_s_ff[1] & ~sclk_s_ff[2];
    rx_byte    = {shift_ff, sdi_s_ff[1]};
    byte_done  = 1'b0;
    nxt_shift      = shift_ff;
    nxt_bits       = bits_ff;
    nxt_pair_pend  = pair_pend_ff;
    nxt_other_mode = other_mode_ff;
    nxt_cfg        = cfg_ff;
    nxt_scan       = scan_ff;
    nxt_scan_wr    = 1'b0;
    nxt_uni        = uni_ff;
    nxt_bip        = bip_ff;
    nxt_oth_v      = 1'b0;
    nxt_oth_b      = oth_b_ff;
    if (cs_s_ff[1]) begin
      nxt_bits       = 3'h0;
      nxt_pair_pend  = 1'b0;
      nxt_other_mode = 1'b0;
    end else if (sclk_rise) begin
      nxt_shift = rx_byte[6:0];
      if (bits_ff == BYTE_LAST_BIT) begin
        byte_done = 1'b1;
        nxt_bits  = 3'h0;
      end else begin
        nxt_bits = bits_ff + 3'h1;
      end
    end
    if (byte_done) begin
      if (pair_pend_ff) begin
        nxt_pair_pend = 1'b0;
        if (cfg_ff[PAIR_LO]) begin
          nxt_bip = rx_byte;
        end else begin
          nxt_uni = rx_byte;
        end
      end else if (other_mode_ff) begin
        nxt_oth_v = 1'b1;
        nxt_oth_b = rx_byte;
      end else if (rx_byte[SEL_SCAN_BIT]) begin
        nxt_scan    = rx_byte;
        nxt_scan_wr = 1'b1;
      end else if (rx_byte[SEL_CFG_BIT]) begin
        nxt_cfg       = rx_byte[5:0];
        nxt_pair_pend = rx_byte[PAIR_HI];
      end else begin
        // rest of frame belongs to the other decoder too
        nxt_oth_v      = 1'b1;
        nxt_oth_b      = rx_byte;
        nxt_other_mode = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sclk_s_ff     <= 3'h0;
      cs_s_ff       <= 2'h3;
      sdi_s_ff      <= 2'h0;
      cnv_s_ff      <= 3'h7;
      shift_ff      <= 7'h00;
      bits_ff       <= 3'h0;
      pair_pend_ff  <= 1'b0;
      other_mode_ff <= 1'b0;
      cfg_ff        <= CFG_RESET;
      scan_ff       <= SCAN_RESET;
      scan_wr_ff    <= 1'b0;
      uni_ff        <= PAIR_RESET;
      bip_ff        <= PAIR_RESET;
      oth_v_ff      <= 1'b0;
      oth_b_ff      <= 8'h00;
    end else begin
      sclk_s_ff     <= nxt_sclk_s;
      cs_s_ff       <= nxt_cs_s;
      sdi_s_ff      <= nxt_sdi_s;
      cnv_s_ff      <= nxt_cnv_s;
      shift_ff      <= nxt_shift;
      bits_ff       <= nxt_bits;
      pair_pend_ff  <= nxt_pair_pend;
      other_mode_ff <= nxt_other_mode;
      cfg_ff        <= nxt_cfg;
      scan_ff       <= nxt_scan;
      scan_wr_ff    <= nxt_scan_wr;
      uni_ff        <= nxt_uni;
      bip_ff        <= nxt_bip;
      oth_v_ff      <= nxt_oth_v;
      oth_b_ff      <= nxt_oth_b;
    end
  end

  // scan sequencer state
  adccmd_seq_e  seq_ff, nxt_seq;
  adccmd_scan_e mode_ff, nxt_mode;
  logic [7:0] dly_ff, nxt_dly;
  logic [2:0] ch_ff, nxt_ch;
  logic [2:0] last_ff, nxt_last;
  logic [4:0] rep_ff, nxt_rep;
  logic       temp_ff, nxt_temp;
  logic       need_ff, nxt_need;
  logic       ref_on_ff, nxt_ref_on;
  logic       req_ff, nxt_req;
  logic       busy_ff, nxt_busy;
  logic [2:0] cch_ff, nxt_cch;
  logic       ctemp_ff, nxt_ctemp;
  logic       cdiff_ff, nxt_cdiff;
  logic       cbip_ff, nxt_cbip;
  logic       tick;
  logic       perm;
  logic       start;
  logic       adv;
  logic       fin;
  logic [2:0] n_eff;
  logic [7:0] diff;

  always_comb begin
    diff  = uni_ff | bip_ff;
    // mode 11 counts serial clock edges, others the internal clock
    tick  = (cfg_ff[CK_HI:CK_LO] == 2'b11) ? sclk_rise : 1'b1;
    perm  = force_reference_on_in
          | ((cfg_ff[REF_HI:REF_LO] == 2'b00)
             & (dac_powered_up_in | dac_pulled_to_ref_in));
    if (cfg_ff[CK_HI]) begin
      start = scan_wr_ff;
    end else if (cfg_ff[CK_LO]) begin
      start = cnv_s_ff[1] & ~cnv_s_ff[2];
    end else begin
      start = ~cnv_s_ff[1] & cnv_s_ff[2];
    end
    n_eff = scan_ff[CH_HI:CH_LO];
    if (pair_bit(n_eff, diff)) begin
      n_eff[0] = 1'b0;
    end
    nxt_seq   = seq_ff;
    nxt_mode  = mode_ff;
    nxt_dly   = dly_ff;
    nxt_ch    = ch_ff;
    nxt_last  = last_ff;
    nxt_rep   = rep_ff;
    nxt_temp  = temp_ff;
    nxt_need  = need_ff;
    nxt_req   = 1'b0;
    nxt_cch   = cch_ff;
    nxt_ctemp = ctemp_ff;
    nxt_cdiff = cdiff_ff;
    nxt_cbip  = cbip_ff;
    adv       = 1'b0;
    case (seq_ff)
      SQ_IDLE: begin
        if (start) begin
          nxt_mode = adccmd_scan_e'(scan_ff[SCAN_HI:SCAN_LO]);
          nxt_temp = scan_ff[TEMP_BIT];
          nxt_need = scan_ff[TEMP_BIT] | ~cfg_ff[REF_LO];
          nxt_rep  = (repeat_results_in == 5'h00) ? 5'h01 : repeat_results_in;
          case (adccmd_scan_e'(scan_ff[SCAN_HI:SCAN_LO]))
            SCAN_TO_N: begin
              nxt_ch   = 3'h0;
              nxt_last = scan_ff[CH_HI:CH_LO];
            end
            SCAN_FROM_N: begin
              nxt_ch   = scan_ff[CH_HI:CH_LO];
              nxt_last = LAST_CH;
            end
            default: begin
              nxt_ch   = n_eff;
              nxt_last = n_eff;
            end
          endcase
          if (scan_ff[TEMP_BIT]) begin
            nxt_dly = perm ? DLY_TEMP_HELD : DLY_TEMP_WAKE;
          end else if (~cfg_ff[REF_LO] & ~ref_on_ff) begin
            nxt_dly = DLY_AIN_WAKE;
          end else begin
            nxt_dly = 8'h00;
          end
          nxt_seq = SQ_WAKE;
        end
      end
      SQ_WAKE: begin
        if (dly_ff == 8'h00) begin
          nxt_seq = temp_ff ? SQ_TEMP : SQ_NEXT;
        end else if (tick) begin
          nxt_dly = dly_ff - 8'h01;
        end
      end
      SQ_TEMP: begin
        nxt_req   = 1'b1;
        nxt_ctemp = 1'b1;
        nxt_temp  = 1'b0;
        nxt_seq   = SQ_WAIT;
      end
      SQ_NEXT: begin
        if (ch_blocked(ch_ff, cfg_ff, diff)) begin
          adv = 1'b1;
        end else begin
          nxt_req   = 1'b1;
          nxt_ctemp = 1'b0;
          nxt_cch   = ch_ff;
          nxt_cdiff = pair_bit(ch_ff, diff);
          nxt_cbip  = pair_bit(ch_ff, bip_ff);
          nxt_seq   = SQ_WAIT;
        end
      end
      SQ_WAIT: begin
        if (conv_done_in) begin
          adv = ~ctemp_ff;
          if (ctemp_ff) begin
            nxt_seq = SQ_NEXT;
          end
        end
      end
      default: nxt_seq = SQ_IDLE;
    endcase
    fin = (mode_ff == SCAN_REPEAT) ? (rep_ff <= 5'h01) :
          (mode_ff == SCAN_SINGLE) | (ch_ff == last_ff);
    if (adv) begin
      if (fin) begin
        nxt_seq = SQ_IDLE;
      end else begin
        nxt_seq = SQ_NEXT;
        if (mode_ff == SCAN_REPEAT) begin
          nxt_rep = rep_ff - 5'h01;
        end else begin
          nxt_ch = ch_ff + 3'h1;
        end
      end
    end
    // auto power-down at scan end unless held on
    nxt_ref_on = perm | ((nxt_seq != SQ_IDLE) & nxt_need);
    // registered so the busy pin carries no decode glitch
    nxt_busy   = (nxt_seq != SQ_IDLE);
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      seq_ff    <= SQ_IDLE;
      mode_ff   <= SCAN_TO_N;
      dly_ff    <= 8'h00;
      ch_ff     <= 3'h0;
      last_ff   <= 3'h0;
      rep_ff    <= 5'h01;
      temp_ff   <= 1'b0;
      need_ff   <= 1'b0;
      ref_on_ff <= 1'b0;
      busy_ff   <= 1'b0;
      req_ff    <= 1'b0;
      cch_ff    <= 3'h0;
      ctemp_ff  <= 1'b0;
      cdiff_ff  <= 1'b0;
      cbip_ff   <= 1'b0;
    end else begin
      seq_ff    <= nxt_seq;
      mode_ff   <= nxt_mode;
      dly_ff    <= nxt_dly;
      ch_ff     <= nxt_ch;
      last_ff   <= nxt_last;
      rep_ff    <= nxt_rep;
      temp_ff   <= nxt_temp;
      need_ff   <= nxt_need;
      ref_on_ff <= nxt_ref_on;
      busy_ff   <= nxt_busy;
      req_ff    <= nxt_req;
      cch_ff    <= nxt_cch;
      ctemp_ff  <= nxt_ctemp;
      cdiff_ff  <= nxt_cdiff;
      cbip_ff   <= nxt_cbip;
    end
  end

  assign clock_mode_out               = cfg_ff[CK_HI:CK_LO];
  assign reference_mode_out           = cfg_ff[REF_HI:REF_LO];
  assign unipolar_pairs_out           = uni_ff;
  assign bipolar_pairs_out            = bip_ff;
  assign analog_input_seven_sel_out   = cfg_ff[CK_HI];
  assign reference_pin_two_is_ref_out = cfg_ff[REF_LO];
  assign reference_power_out          = ref_on_ff;
  assign conv_req_out                 = req_ff;
  assign conv_channel_out             = cch_ff;
  assign conv_temp_out                = ctemp_ff;
  assign conv_differential_out        = cdiff_ff;
  assign conv_bipolar_out             = cbip_ff;
  assign scan_busy_out                = busy_ff;
  assign other_cmd_valid_out          = oth_v_ff;
  assign other_cmd_byte_out           = oth_b_ff;

  AST_SCAN_WRITE: assert property (@(posedge mclk_in) disable iff (rst_in)
    byte_done && rx_byte[7] && !pair_pend_ff && !other_mode_ff
    |=> scan_ff == $past(rx_byte) && scan_wr_ff) else $error("scan write lost");
  AST_CFG_WRITE: assert property (@(posedge mclk_in) disable iff (rst_in)
    byte_done && rx_byte[7:6] == 2'b01 && !pair_pend_ff && !other_mode_ff
    |=> cfg_ff == $past(rx_byte[5:0]) && !scan_wr_ff) else $error("setup write lost");
  AST_CFG_RESET: assert property (@(posedge mclk_in)
    rst_in |=> cfg_ff[CK_HI] && cfg_ff[REF_HI:REF_LO] == 2'b10) else $error("bad reset");
  AST_PAIR_BYTE: assert property (@(posedge mclk_in) disable iff (rst_in)
    byte_done && pair_pend_ff && !cfg_ff[PAIR_LO]
    |=> uni_ff == $past(rx_byte) && !pair_pend_ff) else $error("pairing byte lost");
  AST_REF_HELD: assert property (@(posedge mclk_in) disable iff (rst_in)
    force_reference_on_in |=> ref_on_ff) else $error("reference not held");
  AST_TEMP_WAKE: assert property (@(posedge mclk_in) disable iff (rst_in)
    seq_ff == SQ_IDLE && start && scan_ff[TEMP_BIT] && !perm
    |=> seq_ff == SQ_WAKE && dly_ff == 8'hf4) else $error("temp wake delay");
  AST_TEMP_HELD: assert property (@(posedge mclk_in) disable iff (rst_in)
    seq_ff == SQ_IDLE && start && scan_ff[TEMP_BIT] && perm
    |=> dly_ff == 8'hbc ##1 !req_ff) else $error("held temp delay");
  AST_NO_BLOCKED: assert property (@(posedge mclk_in) disable iff (rst_in)
    req_ff && !ctemp_ff |-> !ch_blocked(cch_ff, cfg_ff, uni_ff | bip_ff))
    else $error("blocked channel converted");
  AST_WRITE_START: assert property (@(posedge mclk_in) disable iff (rst_in)
    scan_wr_ff && cfg_ff[CK_HI] && seq_ff == SQ_IDLE |=> seq_ff == SQ_WAKE)
    else $error("scan write did not start");
endmodule
`default_nettype wire

/* test/adccmd_host_model.sv */
// Purpose: serial host and start-pin driver facing the command decoder
// Assumes: link clock idles low, runs inside frames or as conversion clock, 200 ns period
// Notes:   data line stays driven between frames, set to the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module adccmd_host_model (
  // serial port
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  // start pin
  output logic start_n_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
    start_n_out = 1'b1;
  end

  // data changes while the link clock is low, sampled on its rise
  task automatic shift_bit(input logic b);
    sdi_out = b;
    #100 sclk_out = 1'b1;
    #100 sclk_out = 1'b0;
  endtask

  task automatic end_frame();
    #100 cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #400;
  endtask

  task automatic send_byte(input logic [7:0] b);
    cs_n_out = 1'b0;
    for (int i = 7; i >= 0; i--) shift_bit(b[i]);
    end_frame();
  endtask

  // setup byte and its pairing byte share one frame
  task automatic send_pair(input logic [15:0] w);
    cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) shift_bit(w[i]);
    end_frame();
  endtask

  // low pulse long enough to survive the sync chain
  task automatic pulse_start();
    start_n_out = 1'b0;
    #400 start_n_out = 1'b1;
    #200;
  endtask

  // clock mode 11 times conversions, so the link clock runs between frames
  task automatic free_clock(input int n);
    repeat (n) begin
      #100 sclk_out = 1'b1;
      #100 sclk_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* test/tb_adc_config_scan_command_decoder.sv */
// Purpose: self-checking bench for the ADC command decoder
// Assumes: converter answers each request four cycles later
// Notes:   temperature results are logged as 4'h8, inputs as channel
`timescale 1ns/1ps
`default_nettype none
module tb_adc_config_scan_command_decoder;
  import adccmd_pkg::*;
  logic       mclk_in = 1'b0;
  logic       rst_in;
  logic       sclk_in, cs_n_in, sdi_in, convert_start_pin_n_in;
  logic       force_reference_on_in;
  logic       dac_powered_up_in;
  logic       dac_pulled_to_ref_in;
  logic [4:0] repeat_results_in;
  logic       conv_done_in;
  logic [1:0] pair_kind;
  logic [1:0] clock_mode_out, reference_mode_out;
  logic [7:0] unipolar_pairs_out, bipolar_pairs_out, other_cmd_byte_out;
  logic [7:0] other_byte;
  logic [2:0] conv_channel_out;
  logic       analog_input_seven_sel_out, reference_pin_two_is_ref_out, reference_power_out;
  logic       conv_req_out, conv_temp_out, conv_differential_out, conv_bipolar_out;
  logic       scan_busy_out, other_cmd_valid_out, ref_seen;
  logic [3:0] seen[$];
  int         num_errors, n_tests, busy_cnt, first_wait, done_cnt;

  always #12.5 mclk_in = ~mclk_in;

  adccmd_host_model host_u (
    .sclk_out    (sclk_in),
    .cs_n_out    (cs_n_in),
    .sdi_out     (sdi_in),
    .start_n_out (convert_start_pin_n_in)
  );

  adccmd_decoder dut_u (
    .mclk_in                      (mclk_in),
    .rst_in                       (rst_in),
    .sclk_in                      (sclk_in),
    .cs_n_in                      (cs_n_in),
    .sdi_in                       (sdi_in),
    .convert_start_pin_n_in       (convert_start_pin_n_in),
    .force_reference_on_in        (force_reference_on_in),
    .dac_powered_up_in            (dac_powered_up_in),
    .dac_pulled_to_ref_in         (dac_pulled_to_ref_in),
    .repeat_results_in            (repeat_results_in),
    .conv_done_in                 (conv_done_in),
    .clock_mode_out               (clock_mode_out),
    .reference_mode_out           (reference_mode_out),
    .unipolar_pairs_out           (unipolar_pairs_out),
    .bipolar_pairs_out            (bipolar_pairs_out),
    .analog_input_seven_sel_out   (analog_input_seven_sel_out),
    .reference_pin_two_is_ref_out (reference_pin_two_is_ref_out),
    .reference_power_out          (reference_power_out),
    .conv_req_out                 (conv_req_out),
    .conv_channel_out             (conv_channel_out),
    .conv_temp_out                (conv_temp_out),
    .conv_differential_out        (conv_differential_out),
    .conv_bipolar_out             (conv_bipolar_out),
    .scan_busy_out                (scan_busy_out),
    .other_cmd_valid_out          (other_cmd_valid_out),
    .other_cmd_byte_out           (other_cmd_byte_out)
  );

  // converter stand-in and observers
  always @(negedge mclk_in) begin
    conv_done_in <= 1'b0;
    busy_cnt <= (scan_busy_out === 1'b1) ? busy_cnt + 1 : 0;
    ref_seen <= ref_seen | reference_power_out;
    if (done_cnt == 1) conv_done_in <= 1'b1;
    if (done_cnt != 0) done_cnt <= done_cnt - 1;
    if (conv_req_out === 1'b1) begin
      if (seen.size() == 0) first_wait <= busy_cnt;
      seen.push_back(conv_temp_out ? 4'h8 : {1'b0, conv_channel_out});
      done_cnt <= 4;
      pair_kind <= {conv_differential_out, conv_bipolar_out};
    end
    if (other_cmd_valid_out === 1'b1) other_byte <= other_cmd_byte_out;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_span(input string what, input int lo, input int hi, input int got);
    n_tests++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (scan_busy_out !== 1'b0 && k < 4000) begin
      tick(1);
      k++;
    end
    check("scan finished", 8'h01, {7'h0, k < 4000});
  endtask

  task automatic start_log();
    // cleared off the observer's edge to avoid a race with its updates
    @(posedge mclk_in);
    seen.delete();
    ref_seen = 1'b0;
    @(negedge mclk_in);
  endtask

  task automatic check_log(input logic [3:0] exp[$]);
    wait_idle();
    check("result count", 8'(exp.size()), 8'(seen.size()));
    foreach (exp[i]) check("result", {4'h0, exp[i]}, {4'h0, seen[i]});
  endtask

  task automatic run_scan(input logic [7:0] cmd, input logic [3:0] exp[$]);
    start_log();
    host_u.send_byte(cmd);
    check_log(exp);
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #2_000_000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    rst_in = 1'b1;
    force_reference_on_in = 1'b0;
    dac_powered_up_in = 1'b0;
    dac_pulled_to_ref_in = 1'b0;
    repeat_results_in = 5'h01;
    tick(2);
    rst_in = 1'b0;
    tick(6);
    check("clock mode", 8'h02, {6'h0, clock_mode_out});
    check("ref mode", 8'h02, {6'h0, reference_mode_out});
    check("pin seven", 8'h01, {7'h0, analog_input_seven_sel_out});
    check("pin two", 8'h00, {7'h0, reference_pin_two_is_ref_out});
    check("ref power", 8'h00, {7'h0, reference_power_out});
    host_u.send_pair({8'h46, 8'ha0});
    check("clock mode", 8'h00, {6'h0, clock_mode_out});
    check("ref mode", 8'h01, {6'h0, reference_mode_out});
    check("unipolar", 8'ha0, unipolar_pairs_out);
    check("bipolar", 8'h00, bipolar_pairs_out);
    check("pin two", 8'h01, {7'h0, reference_pin_two_is_ref_out});
    check("pin seven", 8'h00, {7'h0, analog_input_seven_sel_out});
    host_u.send_pair({8'h47, 8'h50});
    check("bipolar", 8'h50, bipolar_pairs_out);
    host_u.send_byte(8'h2b);
    check("foreign byte", 8'h2b, other_byte);
    // clear both pairing registers; clock 10, ref 01
    host_u.send_pair({8'h66, 8'h00});
    host_u.send_pair({8'h67, 8'h00});
    run_scan(8'h98, '{4'h0, 4'h1, 4'h2, 4'h3});
    check("ref used", 8'h00, {7'h0, ref_seen});
    check_span("wake", 0, 3, first_wait);
    run_scan(8'hea, '{4'h5, 4'h7});
    repeat_results_in = 5'h03;
    run_scan(8'hac, '{4'h5, 4'h5, 4'h5});
    run_scan(8'he7, '{4'h8, 4'h4});
    check_span("temp wake", 244, 248, first_wait);
    check("ref used", 8'h01, {7'h0, ref_seen});
    force_reference_on_in = 1'b1;
    tick(4);
    check("ref power", 8'h01, {7'h0, reference_power_out});
    run_scan(8'he7, '{4'h8, 4'h4});
    check_span("held wake", 188, 192, first_wait);
    force_reference_on_in = 1'b0;
    host_u.send_byte(8'h68);
    check("pin two", 8'h00, {7'h0, reference_pin_two_is_ref_out});
    run_scan(8'h9e, '{4'h3});
    check_span("input wake", 218, 222, first_wait);
    tick(2);
    check("ref power", 8'h00, {7'h0, reference_power_out});
    host_u.send_byte(8'h60);
    dac_powered_up_in = 1'b1;
    tick(4);
    check("ref power", 8'h01, {7'h0, reference_power_out});
    dac_powered_up_in = 1'b0;
    dac_pulled_to_ref_in = 1'b1;
    tick(4);
    check("ref power", 8'h01, {7'h0, reference_power_out});
    dac_pulled_to_ref_in = 1'b0;
    tick(4);
    check("ref power", 8'h00, {7'h0, reference_power_out});
    // clock 00: a scan write alone must not start
    host_u.send_byte(8'h48);
    start_log();
    host_u.send_byte(8'h8e);
    tick(20);
    check("busy", 8'h00, {7'h0, scan_busy_out});
    host_u.pulse_start();
    check_log('{4'h1});
    // clock 01: start pin times the acquisition
    host_u.send_byte(8'h58);
    start_log();
    host_u.send_byte(8'h96);
    tick(20);
    check("busy", 8'h00, {7'h0, scan_busy_out});
    host_u.pulse_start();
    check_log('{4'h2});
    // clock 11, ref 10, pair 4/5 bipolar
    host_u.send_pair({8'h7b, 8'h20});
    check("clock mode", 8'h03, {6'h0, clock_mode_out});
    check("pin seven", 8'h01, {7'h0, analog_input_seven_sel_out});
    check("bipolar", 8'h20, bipolar_pairs_out);
    start_log();
    host_u.send_byte(8'hae);
    host_u.free_clock(230);
    check_log('{4'h4});
    check_span("sclk wake", 1760, 1770, first_wait);
    check("pair kind", 8'h03, {6'h0, pair_kind});
    tally_and_finish();
  end
endmodule
`default_nettype wire
